/* File: mops_defines.svh */
`ifndef MOPS_DEFINES_SVH
`define MOPS_DEFINES_SVH
// opcodes
`define MOPS_OP_PICK_INDEX 8'h02
`define MOPS_OP_PICK_FIRST 8'h65
`define MOPS_OP_PICK_SECOND 8'h66
`define MOPS_OP_PICK_THIRD 8'h67
// operand field layout
`define MOPS_IND_BIT 7
`define MOPS_FIELD_MSB 6
// storage limits
`define MOPS_NUM_GREGS 9'h080
`define MOPS_DEF_RAM_WORDS 16'h0400
// pointer descriptor word layout: [31] flash, [30:27] data type, [15:0] addr
`define MOPS_PTR_FLASH_BIT 31
`define MOPS_PTR_TYPE_MSB 30
`define MOPS_PTR_TYPE_LSB 27
`define MOPS_TYPE_SINGLE_FLOAT 4'h1
// element value written on oversize fallback
`define MOPS_NAN_VALUE 32'h7fc00000
`endif

/* File: mops_pkg.sv */
`default_nettype none
package mops_pkg;
  typedef enum logic [1:0] {
    MOPS_MAT_FIRST,
    MOPS_MAT_SECOND,
    MOPS_MAT_THIRD
  } mops_matrix_type;

  typedef struct packed {
    logic in_ram;
    logic [15:0] start;
    logic [7:0] rows;
    logic [7:0] cols;
  } mops_desc_type;
endpackage
`default_nettype wire

/* File: mops_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// register file read port shared by decoder and mops_reg_port
interface mops_reg_if;
  logic req;
  logic [7:0] addr;
  logic ack;
  logic [31:0] data;
  modport client (output req, output addr, input ack, input data);
  modport server (input req, input addr, output ack, output data);
endinterface
`default_nettype wire

/* File: mops_reg_port.sv */
`timescale 1ns/1ps
`default_nettype none
// registers the external read port so the decoder sees a clean handshake
module mops_reg_port (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  mops_reg_if.server rif,
  output logic rd_req_o,
  output logic [7:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic [31:0] rd_data_i
);
  // one read in flight; request drops once the answer is seen
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_req_o <= 1'b0;
      rd_addr_o <= 8'h00;
    end else if (rd_ack_i) begin
      rd_req_o <= 1'b0;
    end else if (rif.req && !rd_req_o) begin
      rd_req_o <= 1'b1;
      rd_addr_o <= rif.addr;
    end
  end
  assign rif.ack = rd_ack_i & rd_req_o;
  assign rif.data = rd_data_i;
endmodule
`default_nettype wire

/* File: mops_decoder.sv */
// What this block does
// RQ1: opcode 66 picks second matrix, 67 third; three operand bytes follow.
// RQ2: start byte bit7 clear is direct register 0..127, set is pointer reg.
// RQ3: row byte bit7 clear is count, set fetches low 8 bits of register.
// RQ4: column byte bit7 clear is count, set fetches low 8 bits of register.
// RQ5: matrix is consecutive locations in registers or RAM from start.
// RQ6: register-resident matrix also loads index register with its start.
// RQ7: matrix elements are 32-bit floats only.
// RQ8: host uses pointer form for any matrix placed in RAM.
// RQ9: flash pointer or non single float pointer ignores whole instruction.
// RQ10: oversize dimensions give a 1x1 matrix whose element 0,0 is NaN.
// RQ11: background process keeps matrices in regs 0..15 inside register 15.
// RQ12: background process should put large matrices at 16..127 or RAM.
// RQ13: opcode 02 with one byte makes that register the index register.
// RQ14: opcode 65 picks first matrix with same layout and index loading.
// RQ15: a separate descriptor is kept for each of the three matrices.
// RQ16: an ignored select leaves descriptors and index register unchanged.
`include "mops_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mops_decoder #(
  parameter logic [15:0] RAM_WORDS = `MOPS_DEF_RAM_WORDS
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_data_i,
  output logic byte_ready_o,
  output logic rd_req_o,
  output logic [7:0] rd_addr_o,
  input wire logic rd_ack_i,
  input wire logic [31:0] rd_data_i,
  output logic [7:0] index_reg_o,
  output mops_pkg::mops_desc_type desc_first_o,
  output mops_pkg::mops_desc_type desc_second_o,
  output mops_pkg::mops_desc_type desc_third_o,
  output logic nan_wr_o,
  output logic nan_in_ram_o,
  output logic [15:0] nan_addr_o,
  output logic [31:0] nan_data_o,
  output logic done_o,
  output logic ignored_o
);
  typedef enum logic [3:0] {
    S_OPC, S_IDX, S_START, S_ROWS, S_COLS,
    S_PTR, S_RFETCH, S_CFETCH, S_CHECK
  } mops_state_type;

  mops_state_type state_r;
  mops_pkg::mops_matrix_type sel_r;
  logic [7:0] start_b_r, rows_b_r, cols_b_r;
  logic [7:0] rows_r, cols_r;
  logic [15:0] start_r;
  logic in_ram_r, bad_ptr_r;
  logic rd_issue_r;
  logic [15:0] area;
  logic [16:0] span;
  logic oversize;
  mops_pkg::mops_desc_type new_desc;

  mops_reg_if rif ();

  mops_reg_port u_port (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .rif(rif),
    .rd_req_o(rd_req_o),
    .rd_addr_o(rd_addr_o),
    .rd_ack_i(rd_ack_i),
    .rd_data_i(rd_data_i)
  );

  // register address for the current fetch state
  always_comb begin
    rif.addr = 8'h00;
    unique case (state_r)
      S_PTR: rif.addr = {1'b0, start_b_r[`MOPS_FIELD_MSB:0]};
      S_RFETCH: rif.addr = {1'b0, rows_b_r[`MOPS_FIELD_MSB:0]};
      S_CFETCH: rif.addr = {1'b0, cols_b_r[`MOPS_FIELD_MSB:0]};
      default: rif.addr = 8'h00;
    endcase
  end
  assign rif.req = (state_r == S_PTR || state_r == S_RFETCH ||
    state_r == S_CFETCH) && !rd_issue_r;

  // elements are contiguous so the span is start plus rows times cols [RQ5]
  assign area = rows_r * cols_r;
  assign span = {1'b0, start_r} + {1'b0, area};
  assign oversize = in_ram_r ? (span > {1'b0, RAM_WORDS}) :
    (span > {8'h00, `MOPS_NUM_GREGS});
  always_comb begin
    new_desc.in_ram = in_ram_r;
    new_desc.start = start_r;
    new_desc.rows = oversize ? 8'h01 : rows_r; // [RQ10]
    new_desc.cols = oversize ? 8'h01 : cols_r; // [RQ10]
  end

  // byte intake only in the opcode and operand collecting states
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      byte_ready_o <= 1'b0;
    end else begin
      byte_ready_o <= (state_r == S_OPC || state_r == S_IDX ||
        state_r == S_START || state_r == S_ROWS || state_r == S_COLS) &&
        !(byte_valid_i && byte_ready_o && state_r == S_COLS);
    end
  end

  // one fetch per state; flag cleared on the answer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_issue_r <= 1'b0;
    end else if (rif.ack) begin
      rd_issue_r <= 1'b0;
    end else if (rif.req) begin
      rd_issue_r <= 1'b1;
    end
  end

  // instruction sequencer
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r <= S_OPC;
      sel_r <= mops_pkg::MOPS_MAT_FIRST;
      start_b_r <= 8'h00;
      rows_b_r <= 8'h00;
      cols_b_r <= 8'h00;
      rows_r <= 8'h00;
      cols_r <= 8'h00;
      start_r <= 16'h0000;
      in_ram_r <= 1'b0;
      bad_ptr_r <= 1'b0;
    end else begin
      unique case (state_r)
        S_OPC: if (byte_valid_i && byte_ready_o) begin
          unique case (byte_data_i)
            `MOPS_OP_PICK_INDEX: state_r <= S_IDX; // [RQ13]
            `MOPS_OP_PICK_FIRST: begin // [RQ14]
              sel_r <= mops_pkg::MOPS_MAT_FIRST;
              state_r <= S_START;
            end
            `MOPS_OP_PICK_SECOND: begin // [RQ1]
              sel_r <= mops_pkg::MOPS_MAT_SECOND;
              state_r <= S_START;
            end
            `MOPS_OP_PICK_THIRD: begin // [RQ1]
              sel_r <= mops_pkg::MOPS_MAT_THIRD;
              state_r <= S_START;
            end
            default: state_r <= S_OPC;
          endcase
        end
        S_IDX: if (byte_valid_i && byte_ready_o) state_r <= S_OPC;
        S_START: if (byte_valid_i && byte_ready_o) begin
          start_b_r <= byte_data_i;
          state_r <= S_ROWS;
        end
        S_ROWS: if (byte_valid_i && byte_ready_o) begin
          rows_b_r <= byte_data_i;
          state_r <= S_COLS;
        end
        S_COLS: if (byte_valid_i && byte_ready_o) begin
          cols_b_r <= byte_data_i;
          bad_ptr_r <= 1'b0;
          rows_r <= {1'b0, rows_b_r[`MOPS_FIELD_MSB:0]}; // [RQ3]
          cols_r <= {1'b0, byte_data_i[`MOPS_FIELD_MSB:0]}; // [RQ4]
          // direct form names register 0..127 [RQ2]
          start_r <= {9'h000, start_b_r[`MOPS_FIELD_MSB:0]};
          in_ram_r <= 1'b0;
          if (start_b_r[`MOPS_IND_BIT]) state_r <= S_PTR;
          else if (rows_b_r[`MOPS_IND_BIT]) state_r <= S_RFETCH;
          else if (byte_data_i[`MOPS_IND_BIT]) state_r <= S_CFETCH;
          else state_r <= S_CHECK;
        end
        S_PTR: if (rif.ack) begin
          // pointer form: matrix lives in RAM [RQ2] [RQ8]
          in_ram_r <= 1'b1;
          start_r <= rif.data[15:0];
          // flash or non single float pointers are refused [RQ9] [RQ7]
          bad_ptr_r <= rif.data[`MOPS_PTR_FLASH_BIT] ||
            (rif.data[`MOPS_PTR_TYPE_MSB:`MOPS_PTR_TYPE_LSB] !=
             `MOPS_TYPE_SINGLE_FLOAT);
          if (rows_b_r[`MOPS_IND_BIT]) state_r <= S_RFETCH;
          else if (cols_b_r[`MOPS_IND_BIT]) state_r <= S_CFETCH;
          else state_r <= S_CHECK;
        end
        S_RFETCH: if (rif.ack) begin
          rows_r <= rif.data[7:0]; // [RQ3]
          state_r <= cols_b_r[`MOPS_IND_BIT] ? S_CFETCH : S_CHECK;
        end
        S_CFETCH: if (rif.ack) begin
          cols_r <= rif.data[7:0]; // [RQ4]
          state_r <= S_CHECK;
        end
        S_CHECK: state_r <= S_OPC;
        default: state_r <= S_OPC;
      endcase
    end
  end

  // descriptors per matrix, untouched when refused [RQ15] [RQ16]
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      desc_first_o <= '0;
      desc_second_o <= '0;
      desc_third_o <= '0;
    end else if (state_r == S_CHECK && !bad_ptr_r) begin
      unique case (sel_r)
        mops_pkg::MOPS_MAT_FIRST: desc_first_o <= new_desc;
        mops_pkg::MOPS_MAT_SECOND: desc_second_o <= new_desc;
        mops_pkg::MOPS_MAT_THIRD: desc_third_o <= new_desc;
        default: desc_first_o <= desc_first_o;
      endcase
    end
  end

  // index register: direct select or register-resident matrix start
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      index_reg_o <= 8'h00;
    end else if (state_r == S_IDX && byte_valid_i && byte_ready_o) begin
      index_reg_o <= byte_data_i; // [RQ13]
    end else if (state_r == S_CHECK && !bad_ptr_r && !in_ram_r) begin
      index_reg_o <= start_r[7:0]; // [RQ6] [RQ14]
    end
  end

  // completion pulses and the NaN write of the fallback element
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      ignored_o <= 1'b0;
      nan_wr_o <= 1'b0;
      nan_in_ram_o <= 1'b0;
      nan_addr_o <= 16'h0000;
      nan_data_o <= 32'h00000000;
    end else begin
      done_o <= state_r == S_CHECK;
      ignored_o <= state_r == S_CHECK && bad_ptr_r; // [RQ9]
      nan_wr_o <= state_r == S_CHECK && !bad_ptr_r && oversize; // [RQ10]
      nan_in_ram_o <= in_ram_r;
      nan_addr_o <= start_r;
      nan_data_o <= `MOPS_NAN_VALUE; // [RQ7]
    end
  end

  a_ignore_keeps_index: assert property (@(posedge clk_sys_i) // [RQ16]
    disable iff (!rst_n_i) (state_r == S_CHECK && bad_ptr_r) |=>
    $stable(index_reg_o)) else $error("index changed on ignored select");
  a_fallback_one: assert property (@(posedge clk_sys_i) // [RQ10]
    disable iff (!rst_n_i) nan_wr_o |-> ((desc_first_o.rows == 8'h01) ||
    (desc_second_o.rows == 8'h01) || (desc_third_o.rows == 8'h01)))
    else $error("nan write without 1x1 descriptor");
  a_nan_value: assert property (@(posedge clk_sys_i) // [RQ7]
    disable iff (!rst_n_i) nan_wr_o |-> nan_data_o == `MOPS_NAN_VALUE)
    else $error("fallback element is not nan");
  a_ignore_no_nan: assert property (@(posedge clk_sys_i) // [RQ9]
    disable iff (!rst_n_i) ignored_o |-> !nan_wr_o && done_o)
    else $error("ignored select wrote or did not finish");
  a_index_direct: assert property (@(posedge clk_sys_i) // [RQ13]
    disable iff (!rst_n_i) (state_r == S_IDX && byte_valid_i && byte_ready_o)
    |=> index_reg_o == $past(byte_data_i))
    else $error("index select not applied");
  a_reg_index_load: assert property (@(posedge clk_sys_i) // [RQ6]
    disable iff (!rst_n_i) (state_r == S_CHECK && !bad_ptr_r && !in_ram_r)
    |=> index_reg_o == $past(start_r[7:0]))
    else $error("index not set to matrix start");
  a_opcode_second: assert property (@(posedge clk_sys_i) // [RQ1]
    disable iff (!rst_n_i) (state_r == S_OPC && byte_valid_i && byte_ready_o
    && byte_data_i == `MOPS_OP_PICK_SECOND) |=> state_r == S_START &&
    sel_r == mops_pkg::MOPS_MAT_SECOND) else $error("opcode 66 missed");
  a_direct_start: assert property (@(posedge clk_sys_i) // [RQ2]
    disable iff (!rst_n_i) (state_r == S_COLS && byte_valid_i && byte_ready_o
    && !start_b_r[`MOPS_IND_BIT]) |=> !in_ram_r && start_r[15:7] == 9'h000)
    else $error("direct start decoded wrongly");
endmodule
`default_nettype wire

/* File: mops_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host byte source plus the register bank behind the read port
module mops_host_model (
  input wire logic clk_sys_i,
  input wire logic byte_ready_i,
  input wire logic rd_req_i,
  input wire logic [7:0] rd_addr_i,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic rd_ack_o,
  output logic [31:0] rd_data_o
);
  // RAM is reached only through pointer words kept here
  logic [31:0] regs [0:255];
  int lat = 0;
  int cnt = 0;
  initial begin
    byte_valid_o = 1'b0;
    byte_data_o = 8'h00;
    rd_ack_o = 1'b0;
    rd_data_o = 32'h0;
  end
  // whole instruction, each byte held until taken; no background
  // process runs, so the low register window never applies
  task automatic send(input logic [7:0] b [4], input int len);
    int n;
    @(posedge clk_sys_i);
    byte_valid_o <= 1'b1;
    for (int i = 0; i < len; i++) begin
      byte_data_o <= b[i];
      n = 0;
      do begin
        @(posedge clk_sys_i);
        n++;
      end while (!byte_ready_i && n < 100);
    end
    byte_valid_o <= 1'b0;
    byte_data_o <= ~byte_data_o;
  endtask
  // answer after lat cycles; idle data toggles so stale values never pass
  always @(posedge clk_sys_i) begin
    if (rd_ack_o) begin
      rd_ack_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
      cnt <= 0;
    end else if (rd_req_i && cnt >= lat) begin
      rd_ack_o <= 1'b1;
      rd_data_o <= regs[rd_addr_i];
    end else begin
      cnt <= rd_req_i ? cnt + 1 : 0;
      rd_data_o <= ~rd_data_o;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "mops_defines.svh"
`default_nettype none
module tb_top;
  logic clk_sys_i, rst_n_i, bvld, brdy, rreq, rack, nwr, nram, done, ign;
  logic [7:0] bdat, raddr, index_reg;
  logic [31:0] rdat, ndat;
  logic [15:0] naddr;
  mops_pkg::mops_desc_type dv [3];
  logic dn, ig, nw, nr;
  logic [15:0] na;
  logic [31:0] nd;
  int errors = 0;
  int cmp_count = 0;
  // small RAM so the fallback boundary is cheap to reach
  mops_decoder #(.RAM_WORDS(16'h0040)) mops_decoder_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .byte_valid_i(bvld),
    .byte_data_i(bdat), .byte_ready_o(brdy), .rd_req_o(rreq),
    .rd_addr_o(raddr), .rd_ack_i(rack), .rd_data_i(rdat),
    .index_reg_o(index_reg), .desc_first_o(dv[0]), .desc_second_o(dv[1]),
    .desc_third_o(dv[2]), .nan_wr_o(nwr), .nan_in_ram_o(nram),
    .nan_addr_o(naddr), .nan_data_o(ndat), .done_o(done), .ignored_o(ign));
  mops_host_model mops_host_model_i (
    .clk_sys_i(clk_sys_i), .byte_ready_i(brdy), .rd_req_i(rreq),
    .rd_addr_i(raddr), .byte_valid_o(bvld), .byte_data_o(bdat),
    .rd_ack_o(rack), .rd_data_o(rdat));
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic mops_pkg::mops_desc_type dsc(input logic m,
      input logic [15:0] s, input logic [7:0] r, input logic [7:0] c);
    return {m, s, r, c};
  endfunction
  // sends a select and records the outcome up to the done pulse
  task automatic run_sel(input logic [7:0] op, s, r, c);
    int n;
    mops_host_model_i.send('{op, s, r, c}, 4);
    {dn, ig, nw, nr, na, nd} = '0;
    n = 0;
    while (dn !== 1'b1 && n < 60) begin
      @(posedge clk_sys_i);
      n++;
      {dn, ig} = {done, ign};
      nw = nw | nwr;
      if (nwr) {nr, na, nd} = {nram, naddr, ndat};
    end
    chk(dn, 1'b1);
  endtask
  // a stray opcode must not swallow the next instruction
  task automatic s_index();
    mops_host_model_i.send('{8'h55, 8'h00, 8'h00, 8'h00}, 1);
    mops_host_model_i.send('{`MOPS_OP_PICK_INDEX, 8'hc8, 8'h00, 8'h00}, 2);
    repeat (2) @(posedge clk_sys_i);
    chk(index_reg, 8'hc8);
  endtask
  task automatic s_direct();
    logic [7:0] ops [3];
    ops = '{`MOPS_OP_PICK_FIRST, `MOPS_OP_PICK_SECOND, `MOPS_OP_PICK_THIRD};
    for (int i = 0; i < 3; i++) begin
      run_sel(ops[i], 8'(20 + i), 8'(2 + i), 8'h03);
      chk(index_reg, 8'(20 + i));
    end
    // all three must still hold their own values afterwards
    for (int i = 0; i < 3; i++)
      chk(dv[i], dsc(1'b0, 16'(20 + i), 8'(2 + i), 8'h03));
  endtask
  // counts fetched slowly; only the low byte of each register counts
  task automatic s_fetch();
    mops_host_model_i.lat = 3;
    mops_host_model_i.regs[5] = 32'h1234_5603;
    mops_host_model_i.regs[6] = 32'hffff_ff04;
    mops_host_model_i.regs[8] = 32'h0800_0010;
    run_sel(`MOPS_OP_PICK_SECOND, 8'h0a, 8'h85, 8'h86);
    chk(dv[1], dsc(1'b0, 16'h000a, 8'h03, 8'h04));
    // pointer followed by a column fetch, then a lone row fetch
    run_sel(`MOPS_OP_PICK_THIRD, 8'h88, 8'h02, 8'h86);
    chk(dv[2], dsc(1'b1, 16'h0010, 8'h02, 8'h04));
    run_sel(`MOPS_OP_PICK_FIRST, 8'h0c, 8'h85, 8'h02);
    chk(dv[0], dsc(1'b0, 16'h000c, 8'h03, 8'h02));
    chk(index_reg, 8'h0c);
    mops_host_model_i.lat = 0;
  endtask
  // RAM matrix keeps the index where it was
  task automatic s_ptr();
    logic [7:0] ix;
    ix = index_reg;
    mops_host_model_i.regs[8] = 32'h0800_0010;
    run_sel(`MOPS_OP_PICK_THIRD, 8'h88, 8'h02, 8'h03);
    chk({ig, dv[2]}, dsc(1'b1, 16'h0010, 8'h02, 8'h03));
    chk(index_reg, ix);
  endtask
  task automatic s_ignore();
    logic [31:0] bad [2];
    mops_pkg::mops_desc_type d0;
    logic [7:0] ix;
    bad = '{32'h8800_0010, 32'h1000_0010};
    foreach (bad[i]) begin
      mops_host_model_i.regs[9] = bad[i];
      {d0, ix} = {dv[0], index_reg};
      run_sel(`MOPS_OP_PICK_FIRST, 8'h89, 8'h02, 8'h02);
      chk(ig, 1'b1);
      chk({dv[0], index_reg}, {d0, ix});
    end
  endtask
  // fallback in registers, then RAM at an exact fit and one row past it
  task automatic s_over();
    logic [7:0] v;
    run_sel(`MOPS_OP_PICK_FIRST, 8'h64, 8'h05, 8'h06);
    chk({ig, nw, nr, na, nd}, {3'b010, 16'h0064, `MOPS_NAN_VALUE});
    chk({dv[0], index_reg}, {dsc(1'b0, 16'h0064, 8'h01, 8'h01), 8'h64});
    mops_host_model_i.regs[8] = 32'h0800_0030;
    for (int r = 4; r < 6; r++) begin
      v = (r == 5) ? 8'h01 : 8'h04;
      run_sel(`MOPS_OP_PICK_SECOND, 8'h88, 8'(r), 8'h04);
      chk({nw, nr, na}, {v[0], v[0], v[0] ? 16'h0030 : 16'h0});
      chk(dv[1], dsc(1'b1, 16'h0030, v, v));
    end
  endtask
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    final_report();
  end
  initial begin
    rst_n_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    chk({dv[0], index_reg}, 64'h0);
    s_index();
    s_direct();
    s_fetch();
    s_ptr();
    s_ignore();
    s_over();
    final_report();
  end
endmodule
`default_nettype wire
